//--- hdl/cache_ctrl_pkg.sv
// constants and types for the cache and isa cycle control register
package cache_ctrl_pkg;
  localparam logic [7:0] CACHE_AT_BUS_CONTROL_OFS = 8'h26;
  localparam logic [7:0] CACHE_AT_BUS_CONTROL_RST = 8'hdf;
  // field positions
  localparam int GLOBAL_NC_BIT = 7;
  localparam int FAST_AT_BIT = 6;
  localparam int IO_NO_DELAY_BIT = 5;
  localparam int TOP_WP_BIT = 4;
  localparam int TURBO_BIT = 3;
  localparam int WT_CPU_BIT = 2;
  localparam int ISA_SYNC_BIT = 1;
  localparam int INTERNAL_BIT = 0;
  // timing counts in isa clocks
  localparam logic [1:0] ALE_DELAY_NORMAL = 2'h2;
  localparam logic [1:0] IO_RECOVERY_CLKS = 2'h3;
  // sync divider base: code 00 gives /6, each step one less
  localparam logic [2:0] ISA_DIV_BASE = 3'h6;
  // top bios segment f0000h-fffffh, upper address bits
  localparam logic [15:0] TOP_SEGMENT_HI = 16'h000f;

  typedef struct packed {
    logic global_nc;
    logic fast_at;
    logic io_no_delay;
    logic top_wp;
    logic turbo;
    logic wt_cpu;
    logic isa_sync;
    logic internal;
  } cfg_bits_t;

  typedef enum logic [1:0] {
    CYC_IDLE = 2'b00,
    CYC_ALE_WAIT = 2'b01,
    CYC_ACTIVE = 2'b10,
    CYC_RECOVER = 2'b11
  } cyc_state_t;

  // state bits are the outputs: {active, interrupt_n, cache enable_n, flush_n}
  typedef enum logic [3:0] {
    MGMT_IDLE = 4'b0111,
    MGMT_FLUSH = 4'b0110,
    MGMT_SIGNAL = 4'b0001,
    MGMT_SIGNAL_WT = 4'b0011,
    MGMT_ACTIVE = 4'b1111
  } mgmt_state_t;
endpackage

//--- hdl/isa_clock_div.sv
// isa bus clock generator: cpu clock divider or oscillator halver
`timescale 1ns/1ps
module isa_clock_div import cache_ctrl_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // mode
  input wire logic sync_mode,
  input wire logic [1:0] div_sel,
  input wire logic ref_rise,
  // clock out
  output logic isa_clk,
  output logic isa_rise
);
  logic [2:0] cnt_reg;
  logic [2:0] div_n;
  logic isa_clk_reg;
  logic isa_rise_reg;
  logic sync_mode_reg;

  assign div_n = ISA_DIV_BASE - {1'b0, div_sel};
  assign isa_clk = isa_clk_reg;
  assign isa_rise = isa_rise_reg;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_mode_reg <= 1'b0;
    end else begin
      sync_mode_reg <= sync_mode;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= 3'h0;
      isa_clk_reg <= 1'b0;
      isa_rise_reg <= 1'b0;
    end else if (sync_mode != sync_mode_reg) begin
      // restart cleanly on a mode change
      cnt_reg <= 3'h0;
      isa_clk_reg <= 1'b0;
      isa_rise_reg <= 1'b0;
    end else if (sync_mode) begin
      isa_rise_reg <= (cnt_reg >= div_n - 3'h1);
      if (cnt_reg >= div_n - 3'h1) begin
        cnt_reg <= 3'h0;
        isa_clk_reg <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 3'h1;
        if (cnt_reg == (div_n >> 1) - 3'h1) begin
          isa_clk_reg <= 1'b0;
        end
      end
    end else begin
      isa_rise_reg <= ref_rise & ~isa_clk_reg;
      if (ref_rise) begin
        isa_clk_reg <= ~isa_clk_reg;
      end
    end
  end
endmodule

//--- hdl/cache_and_at_cycle_control.sv
// cache and isa cycle control register with the logic it steers
`timescale 1ns/1ps
// Functional notes
// - bit 7 set makes every cycle non-cacheable in l1 and l2.
// - bit 6 set shortens address strobe to ale delay by one isa clock.
// - bit 5 clear inserts three isa clocks between back-to-back i/o cycles.
// - bit 4 set blocks l2 writes to f0000h-fffffh.
// - that write protection applies only while the top segment is shadowed.
// - bit 3 clear (slow) requests hold on every second refresh.
// - bit 2 set (write-through) ignores the modified-line snoop hit input.
// - bit 2 clear samples modified-line hit in snoops and allows burst writes.
// - write-back: flush, then cache enable and interrupt, then await cpu ack.
// - bit 1 set: isa clock from cpu divider; clear: oscillator over two.
// - in power management mode the isa clock is oscillator over two.
// - divider codes 00,01,10,11 give cpu clock over 6,5,4,3.
module cache_and_at_cycle_control import cache_ctrl_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // indexed configuration port
  input wire logic [7:0] cfg_index,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  // clocking
  input wire logic oscillator_input,
  input wire logic [1:0] isa_div_sel,
  input wire logic pm_mode,
  output logic isa_bus_clock,
  // cpu cycle
  input wire logic cpu_address_strobe_n,
  input wire logic isa_cycle_sel,
  input wire logic io_cycle,
  input wire logic isa_cycle_done,
  input wire logic [31:0] cpu_addr,
  input wire logic cpu_write,
  input wire logic top_shadowed,
  output logic isa_ale,
  output logic io_recovery_busy,
  output logic l1_noncacheable,
  output logic l2_noncacheable,
  output logic l2_write_block,
  // refresh and hold
  input wire logic refresh_req,
  input wire logic hold_ack,
  output logic hold_req,
  // snoop
  input wire logic snoop_active,
  input wire logic modified_line_snoop_hit_n,
  output logic snoop_hit_modified,
  output logic burst_write_enable,
  // system management entry
  input wire logic mgmt_req,
  input wire logic management_active_ack_n,
  output logic cache_flush_n,
  output logic cache_enable_input_n,
  output logic management_interrupt_n,
  output logic mgmt_active
);
  cfg_bits_t cfg_reg;
  logic [7:0] rdata_reg;
  logic ref_s1_reg, ref_s2_reg, ref_s3_reg;
  logic isa_rise;
  cyc_state_t cyc_reg;
  logic [1:0] cyc_cnt_reg;
  logic io_reg, ale_reg, rec_reg;
  logic nc_reg, wblk_reg;
  logic refresh_odd_reg, hold_reg;
  logic snoop_reg, burst_reg;
  mgmt_state_t mgmt_reg;

  // register access
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_reg <= cfg_bits_t'(CACHE_AT_BUS_CONTROL_RST);
    end else if (cfg_wr && cfg_index == CACHE_AT_BUS_CONTROL_OFS) begin
      cfg_reg <= cfg_bits_t'(cfg_wdata);
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= (cfg_index == CACHE_AT_BUS_CONTROL_OFS) ? cfg_reg : 8'h00;
    end
  end
  assign cfg_rdata = rdata_reg;

  // oscillator pin synchroniser and rising edge
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_s1_reg <= 1'b0;
      ref_s2_reg <= 1'b0;
      ref_s3_reg <= 1'b0;
    end else begin
      ref_s1_reg <= oscillator_input;
      ref_s2_reg <= ref_s1_reg;
      ref_s3_reg <= ref_s2_reg;
    end
  end

  isa_clock_div u_isa_clock_div (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .sync_mode(cfg_reg.isa_sync & ~pm_mode),
    .div_sel(isa_div_sel),
    .ref_rise(ref_s2_reg & ~ref_s3_reg),
    .isa_clk(isa_bus_clock),
    .isa_rise(isa_rise)
  );

  // isa cycle start and i/o recovery
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cyc_reg <= CYC_IDLE;
      cyc_cnt_reg <= 2'h0;
      io_reg <= 1'b0;
      ale_reg <= 1'b0;
    end else begin
      ale_reg <= 1'b0;
      case (cyc_reg)
        CYC_IDLE: begin
          if (!cpu_address_strobe_n && isa_cycle_sel) begin
            io_reg <= io_cycle;
            cyc_cnt_reg <= cfg_reg.fast_at ? ALE_DELAY_NORMAL - 2'h1 : ALE_DELAY_NORMAL;
            cyc_reg <= CYC_ALE_WAIT;
          end
        end
        CYC_ALE_WAIT: begin
          if (isa_rise) begin
            if (cyc_cnt_reg <= 2'h1) begin
              ale_reg <= 1'b1;
              cyc_reg <= CYC_ACTIVE;
            end else begin
              cyc_cnt_reg <= cyc_cnt_reg - 2'h1;
            end
          end
        end
        CYC_ACTIVE: begin
          if (isa_cycle_done) begin
            if (io_reg && !cfg_reg.io_no_delay) begin
              cyc_cnt_reg <= IO_RECOVERY_CLKS;
              cyc_reg <= CYC_RECOVER;
            end else begin
              cyc_reg <= CYC_IDLE;
            end
          end
        end
        CYC_RECOVER: begin
          if (isa_rise) begin
            if (cyc_cnt_reg <= 2'h1) begin
              cyc_reg <= CYC_IDLE;
            end else begin
              cyc_cnt_reg <= cyc_cnt_reg - 2'h1;
            end
          end
        end
        default: cyc_reg <= CYC_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rec_reg <= 1'b0;
    end else begin
      rec_reg <= (cyc_reg == CYC_ACTIVE && isa_cycle_done && io_reg && !cfg_reg.io_no_delay)
        || (cyc_reg == CYC_RECOVER && !(isa_rise && cyc_cnt_reg <= 2'h1));
    end
  end
  assign isa_ale = ale_reg;
  assign io_recovery_busy = rec_reg;

  // cacheability and top segment write protect
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      nc_reg <= 1'b1;
      wblk_reg <= 1'b0;
    end else begin
      nc_reg <= cfg_reg.global_nc;
      wblk_reg <= cfg_reg.top_wp && top_shadowed && cpu_write
        && cpu_addr[31:16] == TOP_SEGMENT_HI;
    end
  end
  assign l1_noncacheable = nc_reg;
  assign l2_noncacheable = nc_reg;
  assign l2_write_block = wblk_reg;

  // slow mode hold on every second refresh
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      refresh_odd_reg <= 1'b0;
      hold_reg <= 1'b0;
    end else begin
      if (refresh_req && !cfg_reg.turbo) begin
        refresh_odd_reg <= ~refresh_odd_reg;
      end
      if (refresh_req && !cfg_reg.turbo && refresh_odd_reg) begin
        hold_reg <= 1'b1;
      end else if (hold_ack) begin
        hold_reg <= 1'b0;
      end
    end
  end
  assign hold_req = hold_reg;

  // snoop handling by cpu cache type
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      snoop_reg <= 1'b0;
      burst_reg <= 1'b0;
    end else begin
      snoop_reg <= !cfg_reg.wt_cpu && snoop_active && !modified_line_snoop_hit_n;
      burst_reg <= !cfg_reg.wt_cpu;
    end
  end
  assign snoop_hit_modified = snoop_reg;
  assign burst_write_enable = burst_reg;

  // system management entry sequence
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mgmt_reg <= MGMT_IDLE;
    end else begin
      case (mgmt_reg)
        MGMT_IDLE: begin
          if (mgmt_req) begin
            mgmt_reg <= cfg_reg.wt_cpu ? MGMT_SIGNAL_WT : MGMT_FLUSH;
          end
        end
        MGMT_FLUSH: mgmt_reg <= MGMT_SIGNAL;
        MGMT_SIGNAL, MGMT_SIGNAL_WT: begin
          if (!management_active_ack_n) begin
            mgmt_reg <= MGMT_ACTIVE;
          end
        end
        MGMT_ACTIVE: begin
          if (management_active_ack_n) begin
            mgmt_reg <= MGMT_IDLE;
          end
        end
        default: mgmt_reg <= MGMT_IDLE;
      endcase
    end
  end
  assign cache_flush_n = mgmt_reg[0];
  assign cache_enable_input_n = mgmt_reg[1];
  assign management_interrupt_n = mgmt_reg[2];
  assign mgmt_active = mgmt_reg[3];

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  noncache_follows_a: assert property ($changed(cfg_reg.global_nc) |=>
    l1_noncacheable == $past(cfg_reg.global_nc) && l2_noncacheable == l1_noncacheable)
    else $error("noncacheable does not follow bit 7");
  ale_fast_a: assert property (cyc_reg == CYC_IDLE && !cpu_address_strobe_n && isa_cycle_sel
    && cfg_reg.fast_at |=> cyc_cnt_reg == ALE_DELAY_NORMAL - 2'h1)
    else $error("fast isa start delay wrong");
  ale_normal_a: assert property (cyc_reg == CYC_IDLE && !cpu_address_strobe_n && isa_cycle_sel
    && !cfg_reg.fast_at |=> cyc_cnt_reg == ALE_DELAY_NORMAL)
    else $error("normal isa start delay wrong");
  io_recovery_a: assert property (cyc_reg == CYC_ACTIVE && isa_cycle_done && io_reg
    && !cfg_reg.io_no_delay |=> cyc_reg == CYC_RECOVER && cyc_cnt_reg == IO_RECOVERY_CLKS
    && io_recovery_busy)
    else $error("i/o recovery not inserted");
  top_protect_a: assert property (l2_write_block |-> $past(cfg_reg.top_wp)
    && $past(cpu_write) && $past(cpu_addr[31:16]) == TOP_SEGMENT_HI)
    else $error("l2 write blocked without cause");
  shadow_gate_a: assert property (!top_shadowed |=> !l2_write_block)
    else $error("protect applied while not shadowed");
  slow_hold_a: assert property (refresh_req && !cfg_reg.turbo && refresh_odd_reg
    |=> hold_req)
    else $error("hold missing on second refresh");
  turbo_hold_a: assert property (cfg_reg.turbo && !hold_req |=> !hold_req)
    else $error("hold raised in turbo mode");
  wt_ignore_a: assert property (cfg_reg.wt_cpu |=> !snoop_hit_modified)
    else $error("modified hit used in write-through mode");
  wb_sample_a: assert property (!cfg_reg.wt_cpu && snoop_active && !modified_line_snoop_hit_n
    |=> snoop_hit_modified && burst_write_enable)
    else $error("modified hit not sampled in write-back mode");
  mgmt_order_a: assert property (mgmt_reg == MGMT_IDLE && mgmt_req && !cfg_reg.wt_cpu
    |=> !cache_flush_n && management_interrupt_n ##1 !management_interrupt_n
    && !cache_enable_input_n)
    else $error("flush does not precede management interrupt");
  pm_clock_a: assert property (pm_mode && $past(pm_mode) && isa_rise
    |-> $past(ref_s2_reg && !ref_s3_reg))
    else $error("power mode not using oscillator clock");

  mgmt_entry_c: cover property (mgmt_reg == MGMT_SIGNAL ##1 mgmt_reg == MGMT_ACTIVE);
  io_recover_c: cover property (cyc_reg == CYC_RECOVER ##1 cyc_reg == CYC_IDLE);
  slow_hold_c: cover property ($rose(hold_req));
endmodule

//--- verif/cpu_core_model.sv
// behavioural cpu core answering the management entry handshake
`timescale 1ns/1ps
module cpu_core_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // management handshake
  input wire logic management_interrupt_n,
  input wire logic leave_mgmt,
  output logic management_active_ack_n
);
  logic [1:0] wait_reg;
  // ack three clocks after the interrupt, drop it when told to leave
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_reg <= 2'h0;
      management_active_ack_n <= 1'b1;
    end else if (leave_mgmt) begin
      wait_reg <= 2'h0;
      management_active_ack_n <= 1'b1;
    end else if (!management_interrupt_n) begin
      if (wait_reg == 2'h2) begin
        management_active_ack_n <= 1'b0;
      end else begin
        wait_reg <= wait_reg + 2'h1;
      end
    end
  end
endmodule

//--- verif/cache_and_at_cycle_control_tb.sv
// self-checking bench for the cache and isa cycle control register
`timescale 1ns/1ps
module cache_and_at_cycle_control_tb;
  import cache_ctrl_pkg::*;
  logic sys_clk = 0, sys_rst = 1, cfg_wr = 0, oscillator_input = 0, pm_mode = 0;
  logic [7:0] cfg_index = 8'h00, cfg_wdata = 8'h00, cfg_rdata;
  logic [1:0] isa_div_sel = 2'h3;
  logic cpu_address_strobe_n = 1, isa_cycle_sel = 0, io_cycle = 0, isa_cycle_done = 0;
  logic [31:0] cpu_addr = 32'h0000_0000;
  logic cpu_write = 0, top_shadowed = 0, refresh_req = 0, hold_ack = 0, snoop_active = 0;
  logic modified_line_snoop_hit_n = 1, mgmt_req = 0, leave_mgmt = 0, management_active_ack_n;
  logic isa_bus_clock, isa_ale, io_recovery_busy, l1_noncacheable, l2_noncacheable;
  logic l2_write_block, hold_req, snoop_hit_modified, burst_write_enable, cache_flush_n;
  logic cache_enable_input_n, management_interrupt_n, mgmt_active;
  int fail_count = 0, check_count = 0, cyc = 0, n, d_fast, d_norm;
  cache_and_at_cycle_control i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .cfg_index(cfg_index), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .oscillator_input(oscillator_input), .isa_div_sel(isa_div_sel), .pm_mode(pm_mode),
    .isa_bus_clock(isa_bus_clock), .cpu_address_strobe_n(cpu_address_strobe_n),
    .isa_cycle_sel(isa_cycle_sel), .io_cycle(io_cycle), .isa_cycle_done(isa_cycle_done),
    .cpu_addr(cpu_addr), .cpu_write(cpu_write), .top_shadowed(top_shadowed),
    .isa_ale(isa_ale), .io_recovery_busy(io_recovery_busy),
    .l1_noncacheable(l1_noncacheable), .l2_noncacheable(l2_noncacheable),
    .l2_write_block(l2_write_block), .refresh_req(refresh_req), .hold_ack(hold_ack),
    .hold_req(hold_req), .snoop_active(snoop_active),
    .modified_line_snoop_hit_n(modified_line_snoop_hit_n),
    .snoop_hit_modified(snoop_hit_modified), .burst_write_enable(burst_write_enable),
    .mgmt_req(mgmt_req), .management_active_ack_n(management_active_ack_n),
    .cache_flush_n(cache_flush_n), .cache_enable_input_n(cache_enable_input_n),
    .management_interrupt_n(management_interrupt_n), .mgmt_active(mgmt_active));
  cpu_core_model i_cpu (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .management_interrupt_n(management_interrupt_n), .leave_mgmt(leave_mgmt),
    .management_active_ack_n(management_active_ack_n));
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  // free running oscillator, out of phase with the cpu clock
  initial begin
    #12;
    forever #50 oscillator_input = ~oscillator_input;
  end
  always @(posedge sys_clk) cyc++;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cfg_write(input logic [7:0] d);
    @(negedge sys_clk);
    cfg_index = CACHE_AT_BUS_CONTROL_OFS;
    cfg_wdata = d;
    cfg_wr = 1;
    @(negedge sys_clk);
    cfg_wr = 0;
    @(negedge sys_clk);
  endtask
  task automatic cfg_read(input logic [7:0] idx, output logic [7:0] d);
    @(negedge sys_clk);
    cfg_index = idx;
    @(negedge sys_clk);
    d = cfg_rdata;
  endtask
  task automatic isa_period(output int p);
    int a;
    @(posedge isa_bus_clock);
    a = cyc;
    @(posedge isa_bus_clock);
    p = cyc - a;
  endtask
  // one isa cycle started just after an isa clock rise; d = cycles to ale
  task automatic isa_cyc(output int d);
    int a;
    @(posedge isa_bus_clock);
    @(negedge sys_clk);
    cpu_address_strobe_n = 0;
    isa_cycle_sel = 1;
    io_cycle = 1;
    a = cyc;
    @(negedge sys_clk);
    cpu_address_strobe_n = 1;
    isa_cycle_sel = 0;
    for (int k = 0; k < 60 && isa_ale !== 1'b1; k++) @(negedge sys_clk);
    d = cyc - a;
    @(negedge sys_clk);
    isa_cycle_done = 1;
    @(negedge sys_clk);
    isa_cycle_done = 0;
  endtask
  task automatic pulse(ref logic s);
    @(negedge sys_clk);
    s = 1;
    @(negedge sys_clk);
    s = 0;
  endtask
  logic [7:0] rd;
  initial begin
    repeat (5) @(negedge sys_clk);
    sys_rst = 0;
    cfg_read(CACHE_AT_BUS_CONTROL_OFS, rd);
    check(rd, CACHE_AT_BUS_CONTROL_RST);
    check(l2_noncacheable, 1);
    cfg_read(8'h27, rd);
    check(rd, 8'h00);
    cfg_write(8'h5f);
    cfg_read(CACHE_AT_BUS_CONTROL_OFS, rd);
    check(rd, 8'h5f);
    check({l1_noncacheable, l2_noncacheable}, 0);
    cpu_addr = 32'h000f_1234;
    cpu_write = 1;
    top_shadowed = 1;
    snoop_active = 1;
    modified_line_snoop_hit_n = 0;
    repeat (2) @(negedge sys_clk);
    check(l2_write_block, 1);
    check({snoop_hit_modified, burst_write_enable}, 0);
    pulse(mgmt_req);
    check({cache_enable_input_n, management_interrupt_n, cache_flush_n}, 3'h5);
    for (int k = 0; k < 20 && mgmt_active !== 1'b1; k++) @(negedge sys_clk);
    check(mgmt_active, 1);
    pulse(leave_mgmt);
    @(negedge sys_clk);
    check(mgmt_active, 0);
    top_shadowed = 0;
    repeat (2) @(negedge sys_clk);
    check(l2_write_block, 0);
    top_shadowed = 1;
    cfg_write(8'h4b);
    check(l2_write_block, 0);
    check({snoop_hit_modified, burst_write_enable}, 2'h3);
    pulse(mgmt_req);
    check(cache_flush_n, 0);
    @(negedge sys_clk);
    check({cache_enable_input_n, management_interrupt_n, cache_flush_n}, 3'h1);
    for (int k = 0; k < 20 && mgmt_active !== 1'b1; k++) @(negedge sys_clk);
    check(mgmt_active, 1);
    pulse(leave_mgmt);
    @(negedge sys_clk);
    check(mgmt_active, 0);
    cfg_write(8'h43);
    pulse(refresh_req);
    @(negedge sys_clk);
    check(hold_req, 0);
    pulse(refresh_req);
    @(negedge sys_clk);
    check(hold_req, 1);
    pulse(hold_ack);
    @(negedge sys_clk);
    check(hold_req, 0);
    isa_cyc(d_fast);
    check(io_recovery_busy, 1);
    repeat (12) @(negedge sys_clk);
    cfg_write(8'h03);
    isa_cyc(d_norm);
    check(8'(d_norm - d_fast), 8'h03);
    repeat (12) @(negedge sys_clk);
    cfg_write(8'h23);
    isa_cyc(n);
    check(io_recovery_busy, 0);
    for (int i = 0; i < 4; i++) begin
      @(negedge sys_clk);
      isa_div_sel = 2'(i);
      isa_period(n);
      isa_period(n);
      check(8'(n), 8'(6 - i));
    end
    @(negedge sys_clk);
    pm_mode = 1;
    isa_period(n);
    isa_period(n);
    check(8'(n), 8'h08);
    @(negedge sys_clk);
    pm_mode = 0;
    cfg_write(8'h21);
    isa_period(n);
    isa_period(n);
    check(8'(n), 8'h08);
    test_done();
  end
  initial begin
    #100us;
    fail_count++;
    test_done();
  end
endmodule
